// file: rtl/hba_pkg.sv
// Constants shared by the heater break alarm detector
package hba_pkg;
	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_KHZ       = 25000;
	localparam int ON_MIN_MS     = 100;
	localparam int ON_MIN_CYCLES = ON_MIN_MS * CLK_KHZ;
	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int CH_NUM    = 2;
	localparam int OUT_NUM   = 4;
	localparam int CUR_W     = 11;
	localparam int ADDR_W    = 8;
	localparam int DATA_W    = 16;
	localparam int ASSIGN_W  = 3;
	localparam int IRQ_W     = 3;
	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_THR0     = 8'h04;
	localparam logic [7:0] ADDR_HYS0     = 8'h0c;
	localparam logic [7:0] ADDR_LATCH    = 8'h14;
	localparam logic [7:0] ADDR_ASSIGN   = 8'h18;
	localparam logic [7:0] ADDR_MON0     = 8'h1c;
	localparam logic [7:0] ADDR_ALARM    = 8'h24;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h28;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h2c;
	localparam logic [7:0] CH_STRIDE     = 8'h04;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_RUN_BIT  = 0;
	localparam int CTRL_CLR_BIT  = 1;
	localparam int CTRL_SRST_BIT = 2;
	localparam int IRQ_REFUSED   = 2;
	// ----------------------------------------------------------------
	// Values in units of 0.1 A, output assignment codes and reset values
	// ----------------------------------------------------------------
	localparam logic [10:0] THR_FORCE_OFF = 11'h000;
	localparam logic [10:0] THR_FORCE_ON  = 11'h3e8;
	localparam logic [10:0] THR_RESET     = 11'h000;
	localparam logic [10:0] HYS_MIN       = 11'h001;
	localparam logic [10:0] HYS_MAX       = 11'h3e8;
	localparam logic [10:0] HYS_RESET     = 11'h001;
	localparam logic [10:0] CUR_MAX       = 11'h44c;
	localparam logic [2:0]  ASSIGN_OFF    = 3'h0;
	localparam logic [2:0]  ASSIGN_MAX    = 3'h4;
	localparam logic [2:0]  ASSIGN_RESET0 = 3'h1;
	localparam logic [2:0]  ASSIGN_RESET1 = 3'h2;
	localparam logic        LATCH_RESET   = 1'b0;
endpackage : hba_pkg

// file: rtl/hba_detector.sv
// Two-channel heater break alarm detector with register port and interrupt
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/10ps

module hba_detector #(
	parameter int ON_MIN_CYCLES = hba_pkg::ON_MIN_CYCLES
) (
	input  wire logic                        ref_clk,
	input  wire logic                        reset,
	input  wire logic [hba_pkg::ADDR_W-1:0]  regAddr,
	input  wire logic [hba_pkg::DATA_W-1:0]  regWrData,
	input  wire logic                        regWr,
	input  wire logic                        regRd,
	output logic      [hba_pkg::DATA_W-1:0]  regRdData,
	input  wire logic [hba_pkg::OUT_NUM-1:0] heatOut,
	input  wire logic [hba_pkg::OUT_NUM-1:0] coolOut,
	input  wire logic [hba_pkg::CH_NUM-1:0]  sensorFittedPin,
	input  wire logic [hba_pkg::CH_NUM-1:0]  sampleValid,
	input  wire logic [hba_pkg::CUR_W-1:0]   currentSensorOne,
	input  wire logic [hba_pkg::CUR_W-1:0]   currentSensorTwo,
	output logic      [hba_pkg::CH_NUM-1:0]  heaterBreakAlarm,
	output logic                             irq
);
	localparam int CNT_W = $clog2(ON_MIN_CYCLES + 1);
	localparam logic [CNT_W-1:0] ON_DONE = CNT_W'(ON_MIN_CYCLES);

	// ----------------------------------------------------------------
	// Address decode helper
	// ----------------------------------------------------------------
	// True when addr hits the per-channel register at base for channel ch
	function automatic logic chHit(input logic [7:0] addr, input logic [7:0] base,
		input int ch);
		chHit = (addr == base + 8'(ch * hba_pkg::CH_STRIDE));
	endfunction : chHit

	logic                        run;
	logic [hba_pkg::CUR_W-1:0]   thr       [hba_pkg::CH_NUM];
	logic [hba_pkg::CUR_W-1:0]   hys       [hba_pkg::CH_NUM];
	logic [hba_pkg::CUR_W-1:0]   monitor   [hba_pkg::CH_NUM];
	logic [hba_pkg::CUR_W-1:0]   curIn     [hba_pkg::CH_NUM];
	logic [hba_pkg::CH_NUM-1:0]  latchEn;
	logic [hba_pkg::ASSIGN_W-1:0] assignSel [hba_pkg::CH_NUM];
	logic [hba_pkg::IRQ_W-1:0]   irqStat;
	logic [hba_pkg::IRQ_W-1:0]   irqMask;
	logic [hba_pkg::CH_NUM-1:0]  alarmPrev;
	logic [hba_pkg::CH_NUM-1:0]  fitSync1;
	logic [hba_pkg::CH_NUM-1:0]  fitSync2;
	logic [hba_pkg::CH_NUM-1:0]  fitSync3;
	logic [hba_pkg::CH_NUM-1:0]  fitted;
	logic [hba_pkg::CH_NUM-1:0]  thrZeroWr;
	logic                        clrCmd;
	logic                        srstCmd;
	logic                        cfgWrTry;
	logic                        refusedWr;
	logic [hba_pkg::IRQ_W-1:0]   irqEvent;
	logic [hba_pkg::DATA_W-1:0]  next_rdData;

	assign curIn[0] = currentSensorOne;
	assign curIn[1] = currentSensorTwo;

	// ----------------------------------------------------------------
	// Command strobes and write checks
	// ----------------------------------------------------------------
	// Commands are write-one pulses, they store nothing
	assign clrCmd  = regWr && regAddr == hba_pkg::ADDR_CTRL && regWrData[hba_pkg::CTRL_CLR_BIT];
	assign srstCmd = regWr && regAddr == hba_pkg::ADDR_CTRL && regWrData[hba_pkg::CTRL_SRST_BIT];
	// Any write to a setting that may only change while stopped
	assign cfgWrTry = regWr && (chHit(regAddr, hba_pkg::ADDR_HYS0, 0)
		|| chHit(regAddr, hba_pkg::ADDR_HYS0, 1) || regAddr == hba_pkg::ADDR_LATCH
		|| regAddr == hba_pkg::ADDR_ASSIGN);
	assign refusedWr = cfgWrTry && run;

	// ----------------------------------------------------------------
	// Sensor-fitted strap synchroniser
	// ----------------------------------------------------------------
	// Three stages; a change is taken once the last two agree
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			fitSync1 <= '0;
			fitSync2 <= '0;
			fitSync3 <= '0;
			fitted   <= '0;
		end else begin
			fitSync1 <= sensorFittedPin;
			fitSync2 <= fitSync1;
			fitSync3 <= fitSync2;
			for (int i = 0; i < hba_pkg::CH_NUM; i++) begin
				if (fitSync2[i] == fitSync3[i]) begin
					fitted[i] <= fitSync3[i];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Run flag
	// ----------------------------------------------------------------
	// Soft restart also stops control so settings can be changed
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			run <= 1'b0;
		end else if (srstCmd) begin
			run <= 1'b0;
		end else if (regWr && regAddr == hba_pkg::ADDR_CTRL) begin
			run <= regWrData[hba_pkg::CTRL_RUN_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Per-channel settings
	// ----------------------------------------------------------------
	// Out-of-range values are dropped so the special codes stay meaningful
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			thr[0]       <= hba_pkg::THR_RESET;
			thr[1]       <= hba_pkg::THR_RESET;
			hys[0]       <= hba_pkg::HYS_RESET;
			hys[1]       <= hba_pkg::HYS_RESET;
			latchEn      <= {hba_pkg::CH_NUM{hba_pkg::LATCH_RESET}};
			assignSel[0] <= hba_pkg::ASSIGN_RESET0;
			assignSel[1] <= hba_pkg::ASSIGN_RESET1;
		end else if (regWr) begin
			for (int i = 0; i < hba_pkg::CH_NUM; i++) begin
				if (chHit(regAddr, hba_pkg::ADDR_THR0, i)
					&& regWrData[hba_pkg::CUR_W-1:0] <= hba_pkg::THR_FORCE_ON
					&& regWrData[hba_pkg::DATA_W-1:hba_pkg::CUR_W] == '0) begin
					thr[i] <= regWrData[hba_pkg::CUR_W-1:0];
				end
				if (!run && chHit(regAddr, hba_pkg::ADDR_HYS0, i)
					&& regWrData[hba_pkg::CUR_W-1:0] >= hba_pkg::HYS_MIN
					&& regWrData[hba_pkg::CUR_W-1:0] <= hba_pkg::HYS_MAX
					&& regWrData[hba_pkg::DATA_W-1:hba_pkg::CUR_W] == '0) begin
					hys[i] <= regWrData[hba_pkg::CUR_W-1:0];
				end
				if (!run && regAddr == hba_pkg::ADDR_ASSIGN
					&& regWrData[i*hba_pkg::ASSIGN_W +: hba_pkg::ASSIGN_W]
					<= hba_pkg::ASSIGN_MAX) begin
					assignSel[i] <= regWrData[i*hba_pkg::ASSIGN_W +: hba_pkg::ASSIGN_W];
				end
			end
			if (!run && regAddr == hba_pkg::ADDR_LATCH) begin
				latchEn <= regWrData[hba_pkg::CH_NUM-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Detection channels
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < hba_pkg::CH_NUM; g++) begin : gChan
			logic [1:0]       selIdx;
			logic             chEnabled;
			logic             onNow;
			logic             qualified;
			logic             evalNow;
			logic             below;
			logic             recovered;
			logic             release_;
			logic [CNT_W-1:0] onCnt;

			assign selIdx    = 2'(assignSel[g] - 3'h1);
			// Cooling outputs and missing sensors give no detection
			assign chEnabled = assignSel[g] != hba_pkg::ASSIGN_OFF && fitted[g]
				&& !coolOut[selIdx];
			assign onNow     = chEnabled && heatOut[selIdx];
			assign qualified = onNow && onCnt == ON_DONE;
			assign evalNow   = qualified && sampleValid[g];
			assign below     = curIn[g] < thr[g];
			assign recovered = {1'b0, curIn[g]} >= {1'b0, thr[g]} + {1'b0, hys[g]};
			assign release_  = clrCmd || srstCmd || thrZeroWr[g];
			assign thrZeroWr[g] = regWr && chHit(regAddr, hba_pkg::ADDR_THR0, g)
				&& regWrData == '0;

			// On-time counter; restarts each time the output turns on
			always_ff @(posedge ref_clk) begin
				if (reset || !onNow || srstCmd) begin
					onCnt <= '0;
				end else if (onCnt != ON_DONE) begin
					onCnt <= onCnt + 1'b1;
				end
			end

			// Monitor holds the last sample, clipped to the top of the range
			always_ff @(posedge ref_clk) begin
				if (reset) begin
					monitor[g] <= '0;
				end else if (sampleValid[g]) begin
					monitor[g] <= (curIn[g] > hba_pkg::CUR_MAX) ? hba_pkg::CUR_MAX
						: curIn[g];
				end
			end

			// Alarm drives only status; heating outputs are never touched
			always_ff @(posedge ref_clk) begin
				if (reset || release_ || !chEnabled) begin
					heaterBreakAlarm[g] <= 1'b0;
				end else if (thr[g] == hba_pkg::THR_FORCE_OFF) begin
					heaterBreakAlarm[g] <= 1'b0;
				end else if (thr[g] == hba_pkg::THR_FORCE_ON) begin
					heaterBreakAlarm[g] <= 1'b1;
				end else if (evalNow && below) begin
					heaterBreakAlarm[g] <= 1'b1;
				end else if (evalNow && recovered && !latchEn[g]) begin
					heaterBreakAlarm[g] <= 1'b0;
				end
			end

			a_force_off: assert property (@(posedge ref_clk) disable iff (reset)
				thr[g] == hba_pkg::THR_FORCE_OFF |=> !heaterBreakAlarm[g])
				else $error("alarm on while threshold forces it off");
			a_force_on: assert property (@(posedge ref_clk) disable iff (reset)
				(thr[g] == hba_pkg::THR_FORCE_ON && chEnabled && !release_)
				|=> heaterBreakAlarm[g])
				else $error("alarm off while threshold forces it on");
			a_short_pulse: assert property (@(posedge ref_clk) disable iff (reset)
				(onNow && !qualified && !release_ && thr[g] != hba_pkg::THR_FORCE_OFF
				&& thr[g] != hba_pkg::THR_FORCE_ON) |=> $stable(heaterBreakAlarm[g]))
				else $error("alarm changed during short on interval");
			a_below_sets: assert property (@(posedge ref_clk) disable iff (reset)
				(evalNow && below && !release_ && thr[g] != hba_pkg::THR_FORCE_OFF)
				|=> heaterBreakAlarm[g])
				else $error("low current did not raise alarm");
			a_off_ignored: assert property (@(posedge ref_clk) disable iff (reset)
				(!onNow && chEnabled && !release_ && thr[g] != hba_pkg::THR_FORCE_OFF
				&& thr[g] != hba_pkg::THR_FORCE_ON) |=> $stable(heaterBreakAlarm[g]))
				else $error("alarm changed while output off");
			a_latch_hold: assert property (@(posedge ref_clk) disable iff (reset)
				(latchEn[g] && heaterBreakAlarm[g] && chEnabled && !release_
				&& thr[g] != hba_pkg::THR_FORCE_OFF) |=> heaterBreakAlarm[g])
				else $error("latched alarm dropped");
		end
	endgenerate

	a_clear_release: assert property (@(posedge ref_clk) disable iff (reset)
		clrCmd |=> heaterBreakAlarm == '0)
		else $error("clear command left an alarm on");
	a_refused_write: assert property (@(posedge ref_clk) disable iff (reset)
		(run && regWr && !srstCmd) |=> $stable(hys[0]) && $stable(hys[1])
		&& $stable(latchEn))
		else $error("setting changed while running");

	// ----------------------------------------------------------------
	// Interrupt status and output
	// ----------------------------------------------------------------
	// Alarm rising edges and refused writes; set wins over write-one clear
	assign irqEvent = {refusedWr, heaterBreakAlarm & ~alarmPrev};

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			alarmPrev <= '0;
			irqStat   <= '0;
			irqMask   <= '0;
			irq       <= 1'b0;
		end else begin
			alarmPrev <= heaterBreakAlarm;
			if (regWr && regAddr == hba_pkg::ADDR_IRQ_STAT) begin
				irqStat <= (irqStat & ~regWrData[hba_pkg::IRQ_W-1:0]) | irqEvent;
			end else begin
				irqStat <= irqStat | irqEvent;
			end
			if (regWr && regAddr == hba_pkg::ADDR_IRQ_MASK) begin
				irqMask <= regWrData[hba_pkg::IRQ_W-1:0];
			end
			irq <= |(irqStat & irqMask);
		end
	end

	a_irq_level: assert property (@(posedge ref_clk) disable iff (reset)
		1'b1 |=> irq == $past(|(irqStat & irqMask)))
		else $error("interrupt output does not follow masked status");

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Unmapped addresses read as zero
	always_comb begin
		next_rdData = '0;
		case (regAddr)
			hba_pkg::ADDR_CTRL: begin
				next_rdData[hba_pkg::CTRL_RUN_BIT] = run;
			end
			hba_pkg::ADDR_THR0: begin
				next_rdData[hba_pkg::CUR_W-1:0] = thr[0];
			end
			hba_pkg::ADDR_THR0 + hba_pkg::CH_STRIDE: begin
				next_rdData[hba_pkg::CUR_W-1:0] = thr[1];
			end
			hba_pkg::ADDR_HYS0: begin
				next_rdData[hba_pkg::CUR_W-1:0] = hys[0];
			end
			hba_pkg::ADDR_HYS0 + hba_pkg::CH_STRIDE: begin
				next_rdData[hba_pkg::CUR_W-1:0] = hys[1];
			end
			hba_pkg::ADDR_LATCH: begin
				next_rdData[hba_pkg::CH_NUM-1:0] = latchEn;
			end
			hba_pkg::ADDR_ASSIGN: begin
				next_rdData[2*hba_pkg::ASSIGN_W-1:0] = {assignSel[1], assignSel[0]};
			end
			hba_pkg::ADDR_MON0: begin
				next_rdData[hba_pkg::CUR_W-1:0] = monitor[0];
			end
			hba_pkg::ADDR_MON0 + hba_pkg::CH_STRIDE: begin
				next_rdData[hba_pkg::CUR_W-1:0] = monitor[1];
			end
			hba_pkg::ADDR_ALARM: begin
				next_rdData[hba_pkg::CH_NUM-1:0] = heaterBreakAlarm;
			end
			hba_pkg::ADDR_IRQ_STAT: begin
				next_rdData[hba_pkg::IRQ_W-1:0] = irqStat;
			end
			hba_pkg::ADDR_IRQ_MASK: begin
				next_rdData[hba_pkg::IRQ_W-1:0] = irqMask;
			end
			default: begin
				next_rdData = '0;
			end
		endcase
	end

	// Data stands only in the cycle after the read strobe
	always_ff @(posedge ref_clk) begin
		if (reset || !regRd) begin
			regRdData <= '0;
		end else begin
			regRdData <= next_rdData;
		end
	end

	a_read_alarm: assert property (@(posedge ref_clk) disable iff (reset)
		(regRd && regAddr == hba_pkg::ADDR_ALARM)
		|=> regRdData[hba_pkg::CH_NUM-1:0] == $past(heaterBreakAlarm))
		else $error("alarm register read wrong");
endmodule : hba_detector

// file: bench/hba_heater_model.sv
// Heating outputs and current measurement standing beside the detector
`timescale 1ns/10ps
module hba_heater_model #(
	parameter int SAMPLE_GAP = 4
) (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic [3:0]  heatCmd,
	input  wire logic [3:0]  coolCmd,
	input  wire logic [1:0]  fittedCmd,
	input  wire logic [10:0] loadOne,
	input  wire logic [10:0] loadTwo,
	output logic      [3:0]  heatOut,
	output logic      [3:0]  coolOut,
	output logic      [1:0]  sensorFittedPin,
	output logic      [1:0]  sampleValid,
	output logic      [10:0] currentSensorOne,
	output logic      [10:0] currentSensorTwo
);
	logic [7:0]  gapCnt;
	logic [10:0] heldOne;
	logic [10:0] heldTwo;

	assign sensorFittedPin = fittedCmd;

	// Control outputs follow the commanded pattern one cycle later
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			heatOut <= 4'h0;
			coolOut <= 4'h0;
		end else begin
			heatOut <= heatCmd;
			coolOut <= coolCmd;
		end
	end

	// Current only flows through a sensor while its heater output is on
	always_comb begin
		heldOne = heatOut[0] ? loadOne : 11'h000;
		heldTwo = heatOut[1] ? loadTwo : 11'h000;
	end

	// Sample pacing counter
	always_ff @(posedge ref_clk) begin
		if (reset || gapCnt == 8'(SAMPLE_GAP - 1)) begin
			gapCnt <= 8'h00;
		end else begin
			gapCnt <= gapCnt + 8'h01;
		end
	end

	// Between samples the data lines toggle, so stale values are never trusted
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sampleValid      <= 2'h0;
			currentSensorOne <= 11'h000;
			currentSensorTwo <= 11'h000;
		end else if (gapCnt == 8'h00) begin
			sampleValid      <= 2'h3;
			currentSensorOne <= heldOne;
			currentSensorTwo <= heldTwo;
		end else begin
			sampleValid      <= 2'h0;
			currentSensorOne <= ~currentSensorOne;
			currentSensorTwo <= ~currentSensorTwo;
		end
	end
endmodule : hba_heater_model

// file: bench/hba_detector_test.sv
// Self-checking testbench for the heater break alarm detector
`timescale 1ns/10ps
module hba_detector_test;
	localparam int ON_MIN = 20;
	localparam logic [7:0] THR1 = hba_pkg::ADDR_THR0 + hba_pkg::CH_STRIDE;
	logic        ref_clk;
	logic        reset;
	logic [7:0]  regAddr;
	logic [15:0] regWrData;
	logic        regWr;
	logic        regRd;
	logic [15:0] regRdData;
	logic [3:0]  heatCmd;
	logic [3:0]  coolCmd;
	logic [1:0]  fittedCmd;
	logic [10:0] loadOne;
	logic [10:0] loadTwo;
	logic [3:0]  heatOut;
	logic [3:0]  coolOut;
	logic [1:0]  sensorFittedPin;
	logic [1:0]  sampleValid;
	logic [10:0] currentSensorOne;
	logic [10:0] currentSensorTwo;
	logic [1:0]  heaterBreakAlarm;
	logic        irq;
	logic        rdSeen;
	logic [31:0] lfsrState;
	logic [15:0] expQ[$];
	string       nameQ[$];
	int          errTotal;
	int          checks;

	hba_detector #(.ON_MIN_CYCLES(ON_MIN)) DUT (.ref_clk(ref_clk), .reset(reset),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .heatOut(heatOut), .coolOut(coolOut),
		.sensorFittedPin(sensorFittedPin), .sampleValid(sampleValid),
		.currentSensorOne(currentSensorOne), .currentSensorTwo(currentSensorTwo),
		.heaterBreakAlarm(heaterBreakAlarm), .irq(irq));

	hba_heater_model farSide (.ref_clk(ref_clk), .reset(reset), .heatCmd(heatCmd),
		.coolCmd(coolCmd), .fittedCmd(fittedCmd), .loadOne(loadOne), .loadTwo(loadTwo),
		.heatOut(heatOut), .coolOut(coolOut), .sensorFittedPin(sensorFittedPin),
		.sampleValid(sampleValid), .currentSensorOne(currentSensorOne),
		.currentSensorTwo(currentSensorTwo));

	// Clock at 25 MHz
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	function automatic logic [31:0] lfsrNext(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsrNext

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			errTotal++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic closeOut();
		$display("Comparisons %0d mismatches %0d", checks, errTotal);
		if (errTotal == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : closeOut

	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : idle

	// A spare cycle after each strobe keeps every strobe edge distinct
	task automatic regWrite(input logic [7:0] a, input logic [15:0] d);
		regAddr   <= a;
		regWrData <= d;
		regWr     <= 1'b1;
		@(posedge ref_clk);
		regWr <= 1'b0;
		@(posedge ref_clk);
	endtask : regWrite

	task automatic regRead(input string what, input logic [7:0] a, input logic [15:0] exp);
		regAddr <= a;
		regRd   <= 1'b1;
		expQ.push_back(exp);
		nameQ.push_back(what);
		@(posedge ref_clk);
		regRd <= 1'b0;
		@(posedge ref_clk);
	endtask : regRead

	task automatic waitAlarm(input int ch, input logic val);
		int n;
		n = 0;
		while (heaterBreakAlarm[ch] !== val && n < 80) begin
			@(negedge ref_clk);
			n++;
		end
		check("alarm pin", {15'h0000, heaterBreakAlarm[ch]}, {15'h0000, val});
		if (heaterBreakAlarm[ch] !== val) begin
			closeOut();
		end
		@(posedge ref_clk);
	endtask : waitAlarm

	// Status lands one edge after its event and the pin one edge after that
	task automatic checkIrq(input logic val);
		@(posedge ref_clk);
		@(negedge ref_clk);
		check("irq", {15'h0000, irq}, {15'h0000, val});
		@(posedge ref_clk);
	endtask : checkIrq

	// Read data stand only in the cycle after the strobe; take the oldest note then
	always @(posedge ref_clk) rdSeen <= regRd;
	always @(negedge ref_clk) begin
		if (rdSeen) begin
			if (expQ.size() == 0) begin
				errTotal++;
				$display("ERROR read data expected none seen %h", regRdData);
			end else begin
				check(nameQ.pop_front(), regRdData, expQ.pop_front());
			end
		end
	end

	// Hang guard
	initial begin
		repeat (60000) @(posedge ref_clk);
		errTotal++;
		closeOut();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{regAddr, regWrData, regWr, regRd, heatCmd, coolCmd} = '0;
		{loadOne, loadTwo, errTotal, checks} = '0;
		fittedCmd = 2'h3;
		lfsrState = 32'h5b37;
		reset = 1'b1;
		idle(16);
		reset <= 1'b0;
		@(posedge ref_clk);
		regRead("thr0", hba_pkg::ADDR_THR0, 16'h0000);
		regRead("hys1", hba_pkg::ADDR_HYS0 + hba_pkg::CH_STRIDE, 16'h0001);
		regRead("latch", hba_pkg::ADDR_LATCH, 16'h0000);
		regRead("assign", hba_pkg::ADDR_ASSIGN, 16'h0011);
		regRead("unmapped", 8'h3c, 16'h0000);
		regWrite(hba_pkg::ADDR_THR0, 16'h0032);
		regWrite(THR1, 16'h0032);
		regWrite(THR1, 16'h03e9);
		regRead("thr1 range", THR1, 16'h0032);
		regWrite(hba_pkg::ADDR_HYS0, 16'h000a);
		regWrite(hba_pkg::ADDR_IRQ_MASK, 16'h0007);
		// Output off, then a short pulse: no current yet no alarm
		idle(3 * ON_MIN);
		regRead("alarm off", hba_pkg::ADDR_ALARM, 16'h0000);
		heatCmd <= 4'h1;
		idle(ON_MIN / 2);
		heatCmd <= 4'h0;
		idle(4);
		regRead("alarm short", hba_pkg::ADDR_ALARM, 16'h0000);
		heatCmd <= 4'h1;
		waitAlarm(0, 1'b1);
		checkIrq(1'b1);
		regRead("irq stat", hba_pkg::ADDR_IRQ_STAT, 16'h0001);
		regWrite(hba_pkg::ADDR_IRQ_STAT, 16'h0001);
		checkIrq(1'b0);
		// Hysteresis band above the threshold
		loadOne <= 11'd55;
		idle(ON_MIN);
		regRead("alarm band", hba_pkg::ADDR_ALARM, 16'h0001);
		loadOne <= 11'd60;
		waitAlarm(0, 1'b0);
		loadOne <= 11'd45;
		waitAlarm(0, 1'b1);
		// Cooling output never judged
		coolCmd <= 4'h1;
		waitAlarm(0, 1'b0);
		idle(ON_MIN);
		regRead("alarm cool", hba_pkg::ADDR_ALARM, 16'h0000);
		coolCmd <= 4'h0;
		waitAlarm(0, 1'b1);
		// Forced settings
		regWrite(hba_pkg::ADDR_THR0, 16'h0000);
		waitAlarm(0, 1'b0);
		loadOne <= 11'd1100;
		regWrite(hba_pkg::ADDR_THR0, 16'h03e8);
		waitAlarm(0, 1'b1);
		regWrite(hba_pkg::ADDR_THR0, 16'h0000);
		waitAlarm(0, 1'b0);
		// Latched alarm and its releases
		regWrite(hba_pkg::ADDR_LATCH, 16'h0001);
		regWrite(hba_pkg::ADDR_THR0, 16'h0032);
		loadOne <= 11'd20;
		waitAlarm(0, 1'b1);
		loadOne <= 11'd200;
		idle(ON_MIN);
		regRead("alarm latch", hba_pkg::ADDR_ALARM, 16'h0001);
		regWrite(hba_pkg::ADDR_CTRL, 16'h0002);
		waitAlarm(0, 1'b0);
		loadOne <= 11'd20;
		waitAlarm(0, 1'b1);
		loadOne <= 11'd200;
		regWrite(hba_pkg::ADDR_CTRL, 16'h0004);
		waitAlarm(0, 1'b0);
		// Setting writes refused while running
		regWrite(hba_pkg::ADDR_IRQ_STAT, 16'h0007);
		regWrite(hba_pkg::ADDR_CTRL, 16'h0001);
		regWrite(hba_pkg::ADDR_HYS0, 16'h0014);
		regWrite(hba_pkg::ADDR_LATCH, 16'h0000);
		regRead("hys0", hba_pkg::ADDR_HYS0, 16'h000a);
		regRead("latch run", hba_pkg::ADDR_LATCH, 16'h0001);
		regRead("irq refused", hba_pkg::ADDR_IRQ_STAT, 16'h0004);
		checkIrq(1'b1);
		regWrite(hba_pkg::ADDR_IRQ_MASK, 16'h0003);
		checkIrq(1'b0);
		regWrite(hba_pkg::ADDR_CTRL, 16'h0000);
		// Second channel and current monitors
		lfsrState = lfsrNext(lfsrState);
		loadTwo <= 11'd100 + {2'h0, lfsrState[8:0]};
		loadOne <= 11'd1500;
		heatCmd <= 4'h3;
		idle(2 * ON_MIN);
		regRead("mon1", hba_pkg::ADDR_MON0 + hba_pkg::CH_STRIDE, {5'h00, loadTwo});
		regRead("mon0", hba_pkg::ADDR_MON0, 16'h044c);
		loadTwo <= 11'd10;
		waitAlarm(1, 1'b1);
		regRead("alarm two", hba_pkg::ADDR_ALARM, 16'h0002);
		// Unmapping sensor two drops its alarm; mapping it back judges again
		regWrite(hba_pkg::ADDR_ASSIGN, 16'h0001);
		waitAlarm(1, 1'b0);
		regRead("assign off", hba_pkg::ADDR_ASSIGN, 16'h0001);
		regWrite(hba_pkg::ADDR_ASSIGN, 16'h0011);
		waitAlarm(1, 1'b1);
		fittedCmd <= 2'h1;
		waitAlarm(1, 1'b0);
		idle(ON_MIN);
		regRead("alarm unfit", hba_pkg::ADDR_ALARM, 16'h0000);
		idle(4);
		closeOut();
	end
endmodule : hba_detector_test
